/* logic/pdws_defs.svh */
// constants for the process data watchdog and status indicator block
`ifndef PDWS_DEFS_SVH
`define PDWS_DEFS_SVH

// register numbers as seen by the protocol engine
`define PDWS_ADDR_WD_TIMEOUT 16'h07D0
`define PDWS_ADDR_FAULT_MODE 16'h07D2
`define PDWS_ADDR_FAIL_REASON 16'h07D4
`define PDWS_ADDR_COMMAND 16'h07D6
`define PDWS_ADDR_STATUS 16'h1F3C
`define PDWS_ADDR_IN_DATA 16'h1F40
`define PDWS_ADDR_OUT_DATA 16'h2328

// reset values
`define PDWS_RST_WD_TIMEOUT 16'h0000
`define PDWS_RST_FAULT_MODE 16'h0000
`define PDWS_RST_FAIL_REASON 16'h0000

// field positions
`define PDWS_STAT_NET_FAIL_BIT 1
`define PDWS_CMD_SET_FAIL_BIT 4
`define PDWS_CMD_ACK_FAIL_BIT 5

// fault response codes
`define PDWS_FMODE_LOW 16'h0000
`define PDWS_FMODE_HIGH 16'h0001
`define PDWS_FMODE_HOLD 16'h0002

// failure reason codes
`define PDWS_REASON_USER 16'h0009
`define PDWS_REASON_WATCHDOG 16'h000C
`define PDWS_REASON_MONITOR 16'h000D

// timing
`define PDWS_CLK_PERIOD_PS 25000
`define PDWS_TICK_PERIOD_PS 1000000000
`define PDWS_BLINK_HALF_MS 250

`endif

/* logic/pdws_pkg.sv */
// types shared by the process data watchdog and status indicator block
package pdws_pkg;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } pdws_led_type;

  typedef struct packed {
    logic [1:0] link;
    logic [1:0] traffic;
    logic sens_ok;
    logic sens_overload;
    logic actr_ok;
    logic over_temp;
    logic [15:0] chan_in;
    logic [15:0] chan_fault;
  } pdws_pins_type;

  typedef struct packed {
    logic dev_ready;
    logic fw_update;
    logic switch_invalid;
    logic conn_possible;
    logic conn_open;
    logic addr_request;
    logic ip_invalid;
    logic ip_conflict;
  } pdws_net_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pdws_req_type;

  typedef struct packed {
    logic valid;
    logic exc;
    logic [15:0] rdata;
  } pdws_resp_type;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_WAIT = 2'b01,
    WD_RUN = 2'b10,
    WD_HALT = 2'b11
  } pdws_wd_state_type;

endpackage

/* logic/pdws_tick.sv */
// millisecond tick and indicator blink generator
`timescale 1ns/1ps
`include "pdws_defs.svh"

module pdws_tick #(
  parameter int MS_CYCLES = 40000
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic ms_tick,
  output logic blink
);

  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic [7:0] half_r;
  logic [7:0] half_nxt;
  logic tick_r;
  logic tick_nxt;
  logic blink_r;
  logic blink_nxt;

  always_comb begin
    div_nxt = div_r + 16'h0001;
    tick_nxt = 1'b0;
    half_nxt = half_r;
    blink_nxt = blink_r;
    if (div_r == 16'(MS_CYCLES - 1)) begin
      div_nxt = 16'h0000;
      tick_nxt = 1'b1;
      half_nxt = half_r + 8'h01;
      if (half_r == 8'(`PDWS_BLINK_HALF_MS - 1)) begin
        half_nxt = 8'h00;
        blink_nxt = ~blink_r;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0000;
      half_r <= 8'h00;
      tick_r <= 1'b0;
      blink_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
      blink_r <= blink_nxt;
    end
  end

  assign ms_tick = tick_r;
  assign blink = blink_r;

endmodule // pdws_tick

/* logic/pdws_watchdog.sv */
// process data watchdog, net failure handling, output drive and status indicators
`timescale 1ns/1ps
`include "pdws_defs.svh"

module pdws_watchdog
  import pdws_pkg::*;
#(
  parameter int MS_CYCLES = `PDWS_TICK_PERIOD_PS / `PDWS_CLK_PERIOD_PS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire pdws_pkg::pdws_req_type req,
  output pdws_pkg::pdws_resp_type resp,
  output logic cmd_error,
  input wire logic mon_timeout,
  input wire logic manual_ack_mode,
  input wire logic [15:0] chan_is_output,
  input wire pdws_pkg::pdws_net_type net_state,
  input wire pdws_pkg::pdws_pins_type pins,
  output logic [15:0] chan_drive,
  output logic net_fail,
  output logic [1:0] port_link_indicator,
  output logic [1:0] port_activity_indicator,
  output pdws_pkg::pdws_led_type ready_led,
  output pdws_pkg::pdws_led_type net_led,
  output pdws_pkg::pdws_led_type sensor_supply_indicator,
  output pdws_pkg::pdws_led_type actuator_supply_indicator,
  output pdws_pkg::pdws_led_type [15:0] chan_led
);

  import pdws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and timebase

  pdws_pins_type pins_meta_r;
  pdws_pins_type pins_r;
  logic ms_tick;
  logic blink;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pins_meta_r <= '0;
      pins_r <= '0;
    end else begin
      pins_meta_r <= pins;
      pins_r <= pins_meta_r;
    end
  end

  pdws_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .ms_tick(ms_tick),
    .blink(blink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register access, watchdog and failure state

  logic [15:0] timeout_r;
  logic [15:0] timeout_nxt;
  logic [15:0] fmode_r;
  logic [15:0] fmode_nxt;
  logic [15:0] reason_r;
  logic [15:0] reason_nxt;
  logic [15:0] out_data_r;
  logic [15:0] out_data_nxt;
  logic [15:0] drive_r;
  logic [15:0] drive_nxt;
  logic [15:0] wd_cnt_r;
  logic [15:0] wd_cnt_nxt;
  pdws_wd_state_type wd_state_r;
  pdws_wd_state_type wd_state_nxt;
  logic fail_r;
  logic fail_nxt;
  pdws_resp_type resp_r;
  pdws_resp_type resp_nxt;
  logic cmd_err_r;
  logic cmd_err_nxt;
  logic out_write;
  logic cmd_write;
  logic cmd_one_hot;
  logic ack;
  logic wd_expire;
  logic user_set;

  // exactly one bit set in the command word
  assign cmd_one_hot = (req.wdata != 16'h0000) && ((req.wdata & (req.wdata - 16'h0001)) == 16'h0000);
  assign out_write = req.wr && (req.addr == `PDWS_ADDR_OUT_DATA);
  assign cmd_write = req.wr && (req.addr == `PDWS_ADDR_COMMAND);
  assign user_set = cmd_write && cmd_one_hot && req.wdata[`PDWS_CMD_SET_FAIL_BIT];

  always_comb begin
    timeout_nxt = timeout_r;
    fmode_nxt = fmode_r;
    reason_nxt = reason_r;
    out_data_nxt = out_data_r;
    wd_cnt_nxt = wd_cnt_r;
    wd_state_nxt = wd_state_r;
    fail_nxt = fail_r;
    cmd_err_nxt = 1'b0;
    resp_nxt = '0;
    ack = 1'b0;
    wd_expire = 1'b0;

    // register writes
    if (req.wr) begin
      resp_nxt.valid = 1'b1;
      case (req.addr)
        `PDWS_ADDR_WD_TIMEOUT: timeout_nxt = req.wdata;
        `PDWS_ADDR_FAULT_MODE: begin
          if (req.wdata <= `PDWS_FMODE_HOLD) begin
            fmode_nxt = req.wdata;
          end else begin
            resp_nxt.exc = 1'b1;
          end
        end
        `PDWS_ADDR_OUT_DATA: out_data_nxt = req.wdata;
        `PDWS_ADDR_COMMAND: begin
          if (!cmd_one_hot) begin
            resp_nxt.exc = 1'b1;
            cmd_err_nxt = 1'b1;
          end
        end
        default: resp_nxt.exc = 1'b1;
      endcase
    end else if (req.rd) begin
      // reads leave the watchdog alone
      resp_nxt.valid = 1'b1;
      case (req.addr)
        `PDWS_ADDR_WD_TIMEOUT: resp_nxt.rdata = timeout_r;
        `PDWS_ADDR_FAULT_MODE: resp_nxt.rdata = fmode_r;
        `PDWS_ADDR_FAIL_REASON: resp_nxt.rdata = reason_r;
        `PDWS_ADDR_STATUS: resp_nxt.rdata[`PDWS_STAT_NET_FAIL_BIT] = fail_r;
        `PDWS_ADDR_IN_DATA: resp_nxt.rdata = pins_r.chan_in & ~chan_is_output;
        `PDWS_ADDR_OUT_DATA: resp_nxt.rdata = out_data_r;
        default: resp_nxt.exc = 1'b1;
      endcase
    end

    // acknowledge paths
    if (manual_ack_mode) begin
      ack = cmd_write && cmd_one_hot && req.wdata[`PDWS_CMD_ACK_FAIL_BIT];
    end else begin
      ack = out_write;
    end

    // watchdog sequence
    case (wd_state_r)
      WD_OFF: begin
        wd_cnt_nxt = 16'h0000;
        if (timeout_r != 16'h0000) begin
          wd_state_nxt = WD_WAIT;
        end
      end
      WD_WAIT: begin
        wd_cnt_nxt = 16'h0000;
        if (out_write) begin
          wd_state_nxt = WD_RUN;
        end
      end
      WD_RUN: begin
        if (out_write) begin
          wd_cnt_nxt = 16'h0000;
        end else if (ms_tick) begin
          // a shortened timeout below the running count expires at the next ms_tick
          if (wd_cnt_r >= timeout_r - 16'h0001) begin
            wd_expire = 1'b1;
            wd_state_nxt = WD_HALT;
          end else begin
            wd_cnt_nxt = wd_cnt_r + 16'h0001;
          end
        end
      end
      WD_HALT: begin
        wd_cnt_nxt = 16'h0000;
        if (ack) begin
          wd_state_nxt = WD_RUN;
        end
      end
      default: wd_state_nxt = WD_OFF;
    endcase

    // a zero timeout is the one way to stop it
    if (timeout_nxt == 16'h0000) begin
      wd_state_nxt = WD_OFF;
    end else if (ack && fail_r && wd_state_r != WD_OFF) begin
      wd_state_nxt = WD_RUN;
      wd_cnt_nxt = 16'h0000;
    end

    // failure flag: any new cause wins over a same-cycle acknowledge
    if (ack) begin
      fail_nxt = 1'b0;
    end
    if (wd_expire || mon_timeout || user_set) begin
      fail_nxt = 1'b1;
    end
    if (user_set) begin
      reason_nxt = `PDWS_REASON_USER;
    end
    if (mon_timeout) begin
      reason_nxt = `PDWS_REASON_MONITOR;
    end
    if (wd_expire) begin
      reason_nxt = `PDWS_REASON_WATCHDOG;
    end

    // output drive follows substitutes while failed
    drive_nxt = out_data_r;
    if (fail_r) begin
      case (fmode_r)
        `PDWS_FMODE_LOW: drive_nxt = 16'h0000;
        `PDWS_FMODE_HIGH: drive_nxt = 16'hFFFF;
        default: drive_nxt = drive_r;
      endcase
    end
    drive_nxt = drive_nxt & chan_is_output;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timeout_r <= `PDWS_RST_WD_TIMEOUT;
      fmode_r <= `PDWS_RST_FAULT_MODE;
      reason_r <= `PDWS_RST_FAIL_REASON;
      out_data_r <= 16'h0000;
      drive_r <= 16'h0000;
      wd_cnt_r <= 16'h0000;
      wd_state_r <= WD_OFF;
      fail_r <= 1'b0;
      resp_r <= '0;
      cmd_err_r <= 1'b0;
    end else begin
      timeout_r <= timeout_nxt;
      fmode_r <= fmode_nxt;
      reason_r <= reason_nxt;
      out_data_r <= out_data_nxt;
      drive_r <= drive_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_state_r <= wd_state_nxt;
      fail_r <= fail_nxt;
      resp_r <= resp_nxt;
      cmd_err_r <= cmd_err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators

  logic [1:0] link_led_r;
  logic [1:0] link_led_nxt;
  logic [1:0] traffic_led_r;
  logic [1:0] traffic_led_nxt;
  pdws_led_type rdy_r;
  pdws_led_type rdy_nxt;
  pdws_led_type net_r;
  pdws_led_type net_nxt;
  pdws_led_type sens_r;
  pdws_led_type sens_nxt;
  pdws_led_type actr_r;
  pdws_led_type actr_nxt;
  pdws_led_type [15:0] chan_r;
  pdws_led_type [15:0] chan_nxt;

  always_comb begin
    link_led_nxt = pins_r.link;
    traffic_led_nxt = pins_r.traffic;

    rdy_nxt = '0;
    if (!net_state.dev_ready) begin
      rdy_nxt = '0;
    end else if (net_state.switch_invalid) begin
      rdy_nxt.red = 1'b1;
    end else if (pins_r.over_temp || !pins_r.sens_ok || pins_r.sens_overload) begin
      rdy_nxt.green = blink;
      rdy_nxt.yellow = ~blink;
    end else if (net_state.fw_update) begin
      rdy_nxt.green = blink;
    end else begin
      rdy_nxt.green = 1'b1;
    end

    net_nxt = '0;
    if (!net_state.dev_ready) begin
      net_nxt = '0;
    end else if (fail_r) begin
      net_nxt.red = 1'b1;
    end else if (net_state.ip_conflict) begin
      net_nxt.red = blink;
    end else if (net_state.ip_invalid) begin
      net_nxt.yellow = 1'b1;
    end else if (net_state.addr_request) begin
      net_nxt.yellow = blink;
    end else if (net_state.conn_open) begin
      net_nxt.green = 1'b1;
    end else if (net_state.conn_possible) begin
      net_nxt.green = blink;
    end

    sens_nxt = '0;
    if (pins_r.sens_overload) begin
      sens_nxt.red = 1'b1;
    end else if (pins_r.sens_ok) begin
      sens_nxt.green = 1'b1;
    end

    actr_nxt = '0;
    actr_nxt.green = pins_r.actr_ok;
  end

  // entry 8*byte+bit, so labels 00..07 then 10..17
  genvar ch;
  generate
    for (ch = 0; ch < 16; ch++) begin : g_chan
      always_comb begin
        chan_nxt[ch] = '0;
        if (!chan_is_output[ch]) begin
          chan_nxt[ch].green = pins_r.chan_in[ch];
        end else if (pins_r.chan_fault[ch]) begin
          chan_nxt[ch].red = 1'b1;
        end else begin
          chan_nxt[ch].yellow = drive_r[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_led_r <= 2'h0;
      traffic_led_r <= 2'h0;
      rdy_r <= '0;
      net_r <= '0;
      sens_r <= '0;
      actr_r <= '0;
      chan_r <= '0;
    end else begin
      link_led_r <= link_led_nxt;
      traffic_led_r <= traffic_led_nxt;
      rdy_r <= rdy_nxt;
      net_r <= net_nxt;
      sens_r <= sens_nxt;
      actr_r <= actr_nxt;
      chan_r <= chan_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign resp = resp_r;
  assign cmd_error = cmd_err_r;
  assign chan_drive = drive_r;
  assign net_fail = fail_r;
  assign port_link_indicator = link_led_r;
  assign port_activity_indicator = traffic_led_r;
  assign ready_led = rdy_r;
  assign net_led = net_r;
  assign sensor_supply_indicator = sens_r;
  assign actuator_supply_indicator = actr_r;
  assign chan_led = chan_r;

endmodule // pdws_watchdog

/* sim/pdws_watchdog_chk.sv */
// concurrent checks on the watchdog block ports
`timescale 1ns/1ps
`include "pdws_defs.svh"
module pdws_watchdog_chk
  import pdws_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire pdws_pkg::pdws_req_type req,
  input wire pdws_pkg::pdws_resp_type resp,
  input wire logic cmd_error,
  input wire logic mon_timeout,
  input wire logic manual_ack_mode,
  input wire pdws_pkg::pdws_net_type net_state,
  input wire pdws_pkg::pdws_pins_type pins,
  input wire logic net_fail,
  input wire logic [1:0] port_link_indicator,
  input wire logic [1:0] port_activity_indicator,
  input wire pdws_pkg::pdws_led_type net_led,
  input wire pdws_pkg::pdws_led_type sensor_supply_indicator,
  input wire pdws_pkg::pdws_led_type actuator_supply_indicator
);
  // pin lamps lag three edges; skip them until the sync flops hold real pin values
  logic [2:0] settle_r;
  logic [2:0] settle_nxt;
  always_comb settle_nxt = (settle_r == 3'h4) ? settle_r : settle_r + 3'h1;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_r <= 3'h0;
    end else begin
      settle_r <= settle_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_link_lamp: assert property (settle_r == 3'h4 |-> port_link_indicator == $past(pins.link, 3))
    else $error("link lamp does not follow port link");
  a_act_lamp: assert property (settle_r == 3'h4 |-> port_activity_indicator == $past(pins.traffic, 3))
    else $error("activity lamp does not follow traffic");
  a_sensor_lamp: assert property (settle_r == 3'h4 |-> sensor_supply_indicator ==
    ($past(pins.sens_overload, 3) ? 3'h1 : ($past(pins.sens_ok, 3) ? 3'h4 : 3'h0)))
    else $error("sensor supply lamp wrong");
  a_actr_lamp: assert property (settle_r == 3'h4 |-> actuator_supply_indicator.green == $past(pins.actr_ok, 3))
    else $error("actuator supply lamp wrong");
  a_mon_fail: assert property (mon_timeout |=> net_fail)
    else $error("monitor timeout did not raise failure");
  a_fail_red: assert property (net_fail && $past(net_fail) && net_state.dev_ready &&
    $past(net_state.dev_ready) |-> net_led == 3'h1)
    else $error("network lamp not steady red in failure");
  a_status_bit: assert property (req.rd && !req.wr && req.addr == `PDWS_ADDR_STATUS |=>
    resp.valid && !resp.exc && resp.rdata == {14'h0, $past(net_fail), 1'b0})
    else $error("status word does not show failure flag");
  a_cmd_reject: assert property (req.wr && req.addr == `PDWS_ADDR_COMMAND && $countones(req.wdata) != 1 |=>
    cmd_error && resp.valid && resp.exc)
    else $error("bad command not refused");
  a_auto_clear: assert property (!manual_ack_mode && net_fail && !mon_timeout && req.wr &&
    req.addr == `PDWS_ADDR_OUT_DATA |=> !net_fail)
    else $error("output write did not clear failure");
endmodule // pdws_watchdog_chk

/* sim/pdws_client.sv */
// remote client model issuing register accesses
`timescale 1ns/1ps
module pdws_client
  import pdws_pkg::*;
(
  input wire logic ref_clk,
  output pdws_pkg::pdws_req_type req,
  input wire pdws_pkg::pdws_resp_type resp
);
  initial req = '0;
  // one-cycle strobe; released fields are inverted so stale values are never read as valid
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic x);
    @(negedge ref_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    for (int i = 0; i < 3 && resp.valid !== 1'b1; i++) @(negedge ref_clk);
    q = resp.valid ? resp.rdata : 16'hXXXX;
    x = resp.valid ? resp.exc : 1'bx;
  endtask
endmodule // pdws_client

/* sim/test_process_data_watchdog_status.sv */
// testbench for the process data watchdog block
`timescale 1ns/1ps
`include "pdws_defs.svh"
module test_process_data_watchdog_status;
  import pdws_pkg::*;
  localparam int MS = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mon_timeout = 1'b0;
  logic manual_ack_mode = 1'b1;
  logic [15:0] chan_is_output = 16'hFFFF;
  pdws_net_type net_state = 8'h88;
  pdws_pins_type pins = '0;
  pdws_req_type req;
  pdws_resp_type resp;
  logic cmd_error;
  logic [15:0] chan_drive;
  logic net_fail;
  logic [1:0] port_link_indicator;
  logic [1:0] port_activity_indicator;
  pdws_led_type ready_led;
  pdws_led_type net_led;
  pdws_led_type sensor_supply_indicator;
  pdws_led_type actuator_supply_indicator;
  pdws_led_type [15:0] chan_led;
  int fails = 0;
  int num_checks = 0;
  logic [15:0] q;
  logic [15:0] sub;
  logic x;
  int idx[5] = '{0, 1, 2, 8, 9};
  logic [2:0] lamp[5] = '{3'h2, 3'h0, 3'h1, 3'h4, 3'h0};
  logic [7:0] nst[4] = '{8'h88, 8'h82, 8'h08, 8'hA8};
  logic [5:0] nexp[4] = '{6'h24, 6'h14, 6'h00, 6'h21};
  always #12.5 ref_clk = ~ref_clk;
  pdws_watchdog #(.MS_CYCLES(MS)) i_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .resp(resp),
    .cmd_error(cmd_error), .mon_timeout(mon_timeout), .manual_ack_mode(manual_ack_mode),
    .chan_is_output(chan_is_output), .net_state(net_state), .pins(pins), .chan_drive(chan_drive),
    .net_fail(net_fail), .port_link_indicator(port_link_indicator), .port_activity_indicator(port_activity_indicator),
    .ready_led(ready_led), .net_led(net_led), .sensor_supply_indicator(sensor_supply_indicator),
    .actuator_supply_indicator(actuator_supply_indicator), .chan_led(chan_led));
  pdws_client i_cli (.ref_clk(ref_clk), .req(req), .resp(resp));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic ex);
    i_cli.acc(1'b1, a, d, q, x);
    chk({15'h0, x}, {15'h0, ex});
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic ex);
    i_cli.acc(1'b0, a, 16'h0, q, x);
    chk({15'h0, x}, {15'h0, ex});
    if (!ex) chk(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // only reads while waiting, so the delay also proves reads never restart the count
  task automatic expire();
    realtime t0;
    int n;
    t0 = $realtime;
    for (int i = 0; i < 1200 && net_fail !== 1'b1; i++) begin
      if (i % 64 == 9) i_cli.acc(1'b0, `PDWS_ADDR_OUT_DATA, 16'h0, q, x);
      @(negedge ref_clk);
    end
    n = int'(($realtime - t0) / 25.0);
    chk(16'(n >= 199 * MS - 8 && n <= 201 * MS + 6), 16'h1);
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #750us;
    fails++;
    print_verdict();
  end
  initial begin
    tick(20);
    rst = 1'b0;
    rd(`PDWS_ADDR_WD_TIMEOUT, `PDWS_RST_WD_TIMEOUT, 1'b0);
    rd(`PDWS_ADDR_FAULT_MODE, `PDWS_RST_FAULT_MODE, 1'b0);
    rd(`PDWS_ADDR_STATUS, 16'h0000, 1'b0);
    wr(`PDWS_ADDR_STATUS, 16'h0002, 1'b1);
    rd(`PDWS_ADDR_COMMAND, 16'h0000, 1'b1);
    wr(16'h0100, 16'h0001, 1'b1);
    wr(`PDWS_ADDR_OUT_DATA, 16'h00FF, 1'b0);
    tick(1000);
    chk({15'h0, net_fail}, 16'h0);
    chk(chan_drive, 16'h00FF);
    $display("test access and reset done");
    wr(`PDWS_ADDR_WD_TIMEOUT, 16'h00C8, 1'b0);
    for (int m = 0; m < 3; m++) begin
      sub = m == 0 ? 16'h0000 : (m == 1 ? 16'hFFFF : 16'h3C02);
      wr(`PDWS_ADDR_FAULT_MODE, 16'(m), 1'b0);
      wr(`PDWS_ADDR_OUT_DATA, 16'h3C00 | 16'(m), 1'b0);
      expire();
      tick(2);
      chk(chan_drive, sub);
      chk(16'(net_led), 16'h0001);
      rd(`PDWS_ADDR_STATUS, 16'h0002, 1'b0);
      rd(`PDWS_ADDR_FAIL_REASON, `PDWS_REASON_WATCHDOG, 1'b0);
      wr(`PDWS_ADDR_OUT_DATA, 16'hA500 | 16'(m), 1'b0);
      tick(2);
      chk({15'h0, net_fail}, 16'h1);
      chk(chan_drive, sub);
      wr(`PDWS_ADDR_COMMAND, 16'h0020, 1'b0);
      tick(2);
      chk({15'h0, net_fail}, 16'h0);
      chk(chan_drive, 16'hA500 | 16'(m));
    end
    expire();
    $display("test fault modes done");
    manual_ack_mode = 1'b0;
    wr(`PDWS_ADDR_OUT_DATA, 16'h0F0F, 1'b0);
    tick(2);
    chk({15'h0, net_fail}, 16'h0);
    chk(chan_drive, 16'h0F0F);
    chk(16'(net_led), 16'h0004);
    mon_timeout = 1'b1;
    tick(1);
    mon_timeout = 1'b0;
    tick(2);
    chk({15'h0, net_fail}, 16'h1);
    chk(chan_drive, 16'h0F0F);
    rd(`PDWS_ADDR_FAIL_REASON, `PDWS_REASON_MONITOR, 1'b0);
    wr(`PDWS_ADDR_FAULT_MODE, 16'h0003, 1'b1);
    rd(`PDWS_ADDR_FAULT_MODE, `PDWS_FMODE_HOLD, 1'b0);
    wr(`PDWS_ADDR_COMMAND, 16'h0030, 1'b1);
    chk({15'h0, net_fail}, 16'h1);
    wr(`PDWS_ADDR_WD_TIMEOUT, 16'h0000, 1'b0);
    wr(`PDWS_ADDR_OUT_DATA, 16'h0001, 1'b0);
    tick(1000);
    chk({15'h0, net_fail}, 16'h0);
    wr(`PDWS_ADDR_COMMAND, 16'h0010, 1'b0);
    rd(`PDWS_ADDR_FAIL_REASON, `PDWS_REASON_USER, 1'b0);
    chk({15'h0, net_fail}, 16'h1);
    wr(`PDWS_ADDR_OUT_DATA, 16'h0001, 1'b0);
    tick(2);
    chk({15'h0, net_fail}, 16'h0);
    $display("test monitor and stop done");
    chan_is_output = 16'h00FF;
    pins = '{link: 2'b01, traffic: 2'b10, sens_ok: 1'b1, sens_overload: 1'b0, actr_ok: 1'b1, over_temp: 1'b0,
      chan_in: 16'h0100, chan_fault: 16'h0004};
    tick(5);
    for (int i = 0; i < 5; i++) chk(16'(chan_led[idx[i]]), 16'(lamp[i]));
    for (int i = 0; i < 4; i++) begin
      net_state = nst[i];
      tick(3);
      chk(16'({net_led, ready_led}), 16'(nexp[i]));
    end
    // one blink half period apart, so both flashing lamps must have flipped exactly once
    net_state = 8'hD0;
    tick(3);
    sub = 16'({net_led, ready_led});
    tick(1000);
    chk(16'({net_led, ready_led}), sub ^ 16'h0024);
    pins.sens_overload = 1'b1;
    pins.actr_ok = 1'b0;
    tick(5);
    chk(16'(sensor_supply_indicator), 16'h0001);
    chk(16'(actuator_supply_indicator), 16'h0000);
    chk(16'(ready_led.green ^ ready_led.yellow), 16'h0001);
    $display("test indicators done");
    print_verdict();
  end
endmodule // test_process_data_watchdog_status
bind pdws_watchdog pdws_watchdog_chk i_chk (.ref_clk(ref_clk), .rst(rst), .req(req), .resp(resp),
  .cmd_error(cmd_error), .mon_timeout(mon_timeout), .manual_ack_mode(manual_ack_mode), .net_state(net_state),
  .pins(pins), .net_fail(net_fail), .port_link_indicator(port_link_indicator),
  .port_activity_indicator(port_activity_indicator), .net_led(net_led),
  .sensor_supply_indicator(sensor_supply_indicator), .actuator_supply_indicator(actuator_supply_indicator));
